/* hw/tsp_defines.svh */
// constants for the thermistor scan and over-temperature protection block
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

// bus widths
`define TSP_ADDR_W          8
`define TSP_DATA_W          32

// timebase and timing figures
`define TSP_CLK_HZ          20000000
`define TSP_CYC_PER_US      (`TSP_CLK_HZ / 1000000)
`define TSP_SCAN_ON_US      5000
`define TSP_SCAN_PERIOD_US  640000
`define TSP_SETTLE_US       1000

// number of cells served
`define TSP_NUM_CELLS       7

// register offsets
`define TSP_REG_CTRL        8'h00
`define TSP_REG_AOSEL       8'h04
`define TSP_REG_BAL         8'h08
`define TSP_REG_STAT        8'h0c
`define TSP_REG_IRQ_STAT    8'h10
`define TSP_REG_IRQ_MASK    8'h14

// control register fields
`define TSP_CTRL_CHG        0
`define TSP_CTRL_DSG        1
`define TSP_CTRL_ASD        2
`define TSP_CTRL_FORCE      3
`define TSP_CTRL_IDIS       4
`define TSP_CTRL_XDIS       5
`define TSP_CTRL_RST        6'h00

// interrupt status fields
`define TSP_IRQ_IOT         0
`define TSP_IRQ_XOT         1

// analog output select codes
`define TSP_AO_CELL1        4'h1
`define TSP_AO_EXT          4'h8
`define TSP_AO_INT          4'h9
`define TSP_AO_RST          4'h0

`endif

/* hw/tsp_overtemp_protect.sv */
// thermistor bias scan, over-temperature shutdown, analog select and balance switches
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "tsp_defines.svh"

module tsp_overtemp_protect #(
  parameter int NCELL           = `TSP_NUM_CELLS,
  parameter int SCAN_ON_CYC     = `TSP_SCAN_ON_US * `TSP_CYC_PER_US,
  parameter int SCAN_PERIOD_CYC = `TSP_SCAN_PERIOD_US * `TSP_CYC_PER_US,
  parameter int SETTLE_CYC      = `TSP_SETTLE_US * `TSP_CYC_PER_US
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  // register port
  input  wire tsp_pkg::tsp_addr_t addr_i,
  input  wire tsp_pkg::tsp_word_t wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output tsp_pkg::tsp_word_t      rdata_o,
  // temperature comparators, asynchronous
  input  wire logic               ext_temp_low_i,
  input  wire logic               ext_temp_recover_i,
  input  wire logic               int_temp_over_i,
  input  wire logic               int_temp_recover_i,
  // overcurrent flags from the current monitor
  input  wire logic               charge_overcurrent_flag_i,
  input  wire logic               discharge_overcurrent_flag_i,
  input  wire logic               short_circuit_flag_i,
  // thermistor bias and analog routing
  output logic                    thermistor_bias_out_o,
  output logic [NCELL-1:0]        route_cell_o,
  output logic                    route_ext_temp_o,
  output logic                    route_int_temp_o,
  // power switches and balancing
  output logic                    charge_switch_ctrl_o,
  output logic                    discharge_switch_ctrl_o,
  output logic [NCELL-1:0]        balance_sw_o,
  // flags and interrupt
  output logic                    internal_overtemp_flag_o,
  output logic                    external_overtemp_flag_o,
  output logic                    irq_o
);
  import tsp_pkg::*;

  localparam int SPW = $clog2(SCAN_PERIOD_CYC);
  localparam int STW = $clog2(SETTLE_CYC + 1);

  // comparator synchronisers: stage one feeds stage two only
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {int_temp_recover_i, int_temp_over_i, ext_temp_recover_i, ext_temp_low_i};
      sync_b <= sync_a;
    end
  end

  wire ext_low_s     = sync_b[0];
  wire ext_recover_s = sync_b[1];
  wire int_over_s    = sync_b[2];
  wire int_recover_s = sync_b[3];

  // software-visible state, plus the scan counter and settle timer
  logic [5:0]       ctrl;
  tsp_aosel_t       aosel;
  logic [NCELL-1:0] bal;
  logic [1:0]       irq_st;
  logic [1:0]       irq_mask;
  logic [SPW-1:0]   scan_cnt;
  logic [STW-1:0]   settle_cnt;
  logic             int_sd;
  logic             ext_sd;

  // address decode
  wire sel_ctrl  = addr_i == `TSP_REG_CTRL;
  wire sel_aosel = addr_i == `TSP_REG_AOSEL;
  wire sel_bal   = addr_i == `TSP_REG_BAL;
  wire sel_stat  = addr_i == `TSP_REG_STAT;
  wire sel_ist   = addr_i == `TSP_REG_IRQ_STAT;
  wire sel_imask = addr_i == `TSP_REG_IRQ_MASK;

  wire ctrl_asd   = ctrl[`TSP_CTRL_ASD];
  wire ctrl_force = ctrl[`TSP_CTRL_FORCE];
  wire ctrl_idis  = ctrl[`TSP_CTRL_IDIS];
  wire ctrl_xdis  = ctrl[`TSP_CTRL_XDIS];

  // periodic scan counter runs freely so the window phase never drifts
  wire            scan_wrap     = scan_cnt == SPW'(SCAN_PERIOD_CYC - 1);
  wire [SPW-1:0]  next_scan_cnt = scan_wrap ? '0 : scan_cnt + SPW'(1);
  wire            scan_win      = !ctrl_asd && (scan_cnt < SPW'(SCAN_ON_CYC));

  // bias request sources are or-ed, so no source can cut another short
  wire host_ext  = aosel == `TSP_AO_EXT;
  wire oc_any    = charge_overcurrent_flag_i | discharge_overcurrent_flag_i
                 | short_circuit_flag_i;
  wire next_bias = ctrl_force | host_ext | scan_win | oc_any;

  // settle timer: the comparator is only trusted once the divider has settled
  wire            settled        = settle_cnt == STW'(SETTLE_CYC);
  wire [STW-1:0]  next_settle    = !thermistor_bias_out_o ? '0 :
                                   settled ? settle_cnt : settle_cnt + STW'(1);
  wire            ext_fail       = settled && ext_low_s;
  wire            ext_ok         = settled && ext_recover_s;

  // shutdown latches, released only by the recovery comparators
  wire next_int_sd = int_sd ? !int_recover_s : (int_over_s && !ctrl_idis);
  wire next_ext_sd = ext_sd ? !ext_ok : (ext_fail && !ctrl_xdis);
  wire shutdown    = int_sd | ext_sd;
  wire next_shut   = next_int_sd | next_ext_sd;

  // control writes; switch bits are refused during shutdown and cleared on entry
  wire       ctrl_wr = wr_i && sel_ctrl;
  wire       sw_wr   = ctrl_wr && !shutdown;
  wire       next_chg = next_shut ? 1'b0 :
                        sw_wr ? wdata_i[`TSP_CTRL_CHG] : ctrl[`TSP_CTRL_CHG];
  wire       next_dsg = next_shut ? 1'b0 :
                        sw_wr ? wdata_i[`TSP_CTRL_DSG] : ctrl[`TSP_CTRL_DSG];
  wire [3:0] next_cfg = ctrl_wr ? wdata_i[5:2] : ctrl[5:2];
  wire [5:0] next_ctrl = {next_cfg, next_dsg, next_chg};

  // balance register: one bit per cell, frozen while shut down
  wire                   bal_wr   = wr_i && sel_bal && !shutdown;
  wire [NCELL-1:0]       next_bal = bal_wr ? wdata_i[NCELL-1:0] : bal;

  // analog select stays writable in shutdown so monitoring goes on
  wire        aosel_wr   = wr_i && sel_aosel;
  tsp_aosel_t next_aosel;
  assign next_aosel = aosel_wr ? wdata_i[3:0] : aosel;

  // select decode; codes outside the table route nothing
  wire [NCELL-1:0] cell_hit;
  genvar k;
  generate
    for (k = 0; k < NCELL; k++) begin : g_cell
      assign cell_hit[k] = aosel == (`TSP_AO_CELL1 + 4'(k));
    end
  endgenerate
  wire int_hit = aosel == `TSP_AO_INT;

  // sticky interrupt flags, write one to clear; a new event beats the clear
  wire       ist_wr      = wr_i && sel_ist;
  wire [1:0] ist_clr     = ist_wr ? wdata_i[1:0] : 2'h0;
  wire [1:0] ist_set     = {ext_fail, int_over_s};
  wire [1:0] next_irq_st = (irq_st & ~ist_clr) | ist_set;
  wire [1:0] next_mask   = (wr_i && sel_imask) ? wdata_i[1:0] : irq_mask;

  // read mux; unmapped addresses read zero
  wire [31:0] stat_word = {27'h0, settled, thermistor_bias_out_o, shutdown, ext_sd, int_sd};
  wire [31:0] rd_word   = sel_ctrl  ? {26'h0, ctrl} :
                          sel_aosel ? {28'h0, aosel} :
                          sel_bal   ? 32'(bal) :
                          sel_stat  ? stat_word :
                          sel_ist   ? {30'h0, irq_st} :
                          sel_imask ? {30'h0, irq_mask} : 32'h0;

  // state registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl       <= `TSP_CTRL_RST;
      aosel      <= `TSP_AO_RST;
      bal        <= '0;
      irq_st     <= 2'h0;
      irq_mask   <= 2'h0;
      scan_cnt   <= '0;
      settle_cnt <= '0;
      int_sd     <= 1'b0;
      ext_sd     <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      aosel      <= next_aosel;
      bal        <= next_bal;
      irq_st     <= next_irq_st;
      irq_mask   <= next_mask;
      scan_cnt   <= next_scan_cnt;
      settle_cnt <= next_settle;
      int_sd     <= next_int_sd;
      ext_sd     <= next_ext_sd;
    end
  end

  // switch, balance, flag and irq outputs are registered from next-state values so they line up with the state; bias and routes lag a cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      thermistor_bias_out_o    <= 1'b0;
      route_cell_o             <= '0;
      route_ext_temp_o         <= 1'b0;
      route_int_temp_o         <= 1'b0;
      charge_switch_ctrl_o     <= 1'b0;
      discharge_switch_ctrl_o  <= 1'b0;
      balance_sw_o             <= '0;
      internal_overtemp_flag_o <= 1'b0;
      external_overtemp_flag_o <= 1'b0;
      irq_o                    <= 1'b0;
      rdata_o                  <= '0;
    end else begin
      thermistor_bias_out_o    <= next_bias;
      route_cell_o             <= cell_hit;
      route_ext_temp_o         <= host_ext;
      route_int_temp_o         <= int_hit;
      charge_switch_ctrl_o     <= next_chg;
      discharge_switch_ctrl_o  <= next_dsg;
      balance_sw_o             <= next_shut ? '0 : next_bal;
      internal_overtemp_flag_o <= next_irq_st[`TSP_IRQ_IOT];
      external_overtemp_flag_o <= next_irq_st[`TSP_IRQ_XOT];
      irq_o                    <= |(next_irq_st & next_mask);
      rdata_o                  <= rd_i ? rd_word : '0;
    end
  end

  // checks kept beside the logic they guard
  // checked cycle by cycle, since setting the disable bit may cut a window short
  a_scan_window: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ctrl_asd && scan_cnt < SPW'(SCAN_ON_CYC) |=> thermistor_bias_out_o)
    else $error("auto scan window did not raise bias");

  a_scan_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ctrl_force && !host_ext && !oc_any && scan_cnt >= SPW'(SCAN_ON_CYC) |=> !thermistor_bias_out_o)
    else $error("bias on outside the scan window");

  a_scan_disable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctrl_asd && !ctrl_force && !host_ext && !oc_any |=> !thermistor_bias_out_o)
    else $error("bias on with scan disabled and no other source");

  a_settle_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(thermistor_bias_out_o) |-> !ext_fail [*2])
    else $error("comparator sampled before settle time");

  a_ext_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ext_fail |=> external_overtemp_flag_o)
    else $error("external fail did not set flag");

  a_host_bias: assert property (@(posedge clk_i) disable iff (!rstn_i)
    host_ext |=> thermistor_bias_out_o && route_ext_temp_o)
    else $error("external select lost bias or route");

  a_force_bias: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctrl_force |=> thermistor_bias_out_o)
    else $error("force-on did not hold bias");

  a_wake_bias: assert property (@(posedge clk_i) disable iff (!rstn_i)
    oc_any |=> thermistor_bias_out_o)
    else $error("overcurrent flag did not raise bias");

  a_shut_fets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    shutdown |-> !charge_switch_ctrl_o && !discharge_switch_ctrl_o
                 && !ctrl[`TSP_CTRL_CHG] && !ctrl[`TSP_CTRL_DSG])
    else $error("switch on during shutdown");

  a_shut_bal: assert property (@(posedge clk_i) disable iff (!rstn_i)
    shutdown |-> balance_sw_o == '0)
    else $error("balancing active during shutdown");

  a_write_ignore: assert property (@(posedge clk_i) disable iff (!rstn_i)
    shutdown && wr_i && sel_bal |=> bal == $past(bal))
    else $error("balance write accepted during shutdown");

  a_int_disable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !int_sd && ctrl_idis |=> !int_sd)
    else $error("internal shutdown despite disable");

  a_ext_disable: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ext_sd && ctrl_xdis |=> !ext_sd)
    else $error("external shutdown despite disable");

  a_bal_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bal_wr && !next_shut |=> balance_sw_o == NCELL'($past(wdata_i)))
    else $error("balance switches do not follow write");

  a_unused_code: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cell_hit == '0 && !host_ext && !int_hit
    |=> route_cell_o == '0 && !route_ext_temp_o && !route_int_temp_o)
    else $error("unused select code routed something");

  // shutdown entry, flags and interrupt
  a_int_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !int_sd && int_over_s && !ctrl_idis |=> int_sd)
    else $error("internal over-temperature did not shut down");

  a_ext_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ext_sd && ext_fail && !ctrl_xdis |=> ext_sd)
    else $error("external over-temperature did not shut down");

  a_int_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    int_over_s |=> internal_overtemp_flag_o)
    else $error("internal over-temperature did not set flag");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_st[`TSP_IRQ_IOT] && !ist_clr[`TSP_IRQ_IOT] |=> internal_overtemp_flag_o)
    else $error("internal flag lost without a clear");

  a_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_o |-> |(irq_st & irq_mask))
    else $error("interrupt high with no unmasked flag");

  // a latched shutdown only lets go on the recovery comparator
  a_int_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    int_sd && !int_recover_s |=> int_sd)
    else $error("internal shutdown released early");

  a_ext_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ext_sd && !ext_ok |=> ext_sd)
    else $error("external shutdown released early");

  // host writes during shutdown
  a_chg_ignore: assert property (@(posedge clk_i) disable iff (!rstn_i)
    shutdown && ctrl_wr |=> !ctrl[`TSP_CTRL_CHG] && !ctrl[`TSP_CTRL_DSG])
    else $error("switch bit write accepted during shutdown");

  a_aosel_live: assert property (@(posedge clk_i) disable iff (!rstn_i)
    aosel_wr |=> aosel == 4'($past(wdata_i)))
    else $error("analog select write not taken");

  // routing of the select codes
  a_cell_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
    aosel == `TSP_AO_CELL1 |=> route_cell_o[0])
    else $error("first cell not routed");

  a_route_int: assert property (@(posedge clk_i) disable iff (!rstn_i)
    aosel == `TSP_AO_INT |=> route_int_temp_o && !route_ext_temp_o)
    else $error("internal temperature not routed");

endmodule

/* hw/tsp_pkg.sv */
// types shared by the thermistor scan and over-temperature protection block
`include "tsp_defines.svh"
package tsp_pkg;
  typedef logic [`TSP_ADDR_W-1:0] tsp_addr_t;
  typedef logic [`TSP_DATA_W-1:0] tsp_word_t;
  typedef logic [3:0]             tsp_aosel_t;
endpackage

/* sim/testbench.sv */
// self-checking bench for the thermistor scan and over-temperature block
`timescale 1ns/1ps
`include "tsp_defines.svh"
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t %s", $time, m); end end
module testbench;
  import tsp_pkg::*;
  logic        clk, rstn, wr, rd, ext_low, ext_rec, int_over, int_rec, hot, bias;
  logic        charge_overcurrent_flag, discharge_overcurrent_flag, sc, route_ext, route_int, chg, dsg, internal_overtemp_flag, external_overtemp_flag, irq;
  logic        rd_seen = 1'b0;
  logic [6:0]  route_cell, bal_sw;
  tsp_addr_t   addr;
  tsp_word_t   wdata, rdata, seed, v;
  tsp_word_t   exp_q[$];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          n;

  tsp_overtemp_protect #(.SCAN_ON_CYC(5), .SCAN_PERIOD_CYC(64), .SETTLE_CYC(2)) dut (
    .clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .ext_temp_low_i(ext_low), .ext_temp_recover_i(ext_rec),
    .int_temp_over_i(int_over), .int_temp_recover_i(int_rec),
    .charge_overcurrent_flag_i(charge_overcurrent_flag), .discharge_overcurrent_flag_i(discharge_overcurrent_flag),
    .short_circuit_flag_i(sc), .thermistor_bias_out_o(bias), .route_cell_o(route_cell),
    .route_ext_temp_o(route_ext), .route_int_temp_o(route_int),
    .charge_switch_ctrl_o(chg), .discharge_switch_ctrl_o(dsg), .balance_sw_o(bal_sw),
    .internal_overtemp_flag_o(internal_overtemp_flag), .external_overtemp_flag_o(external_overtemp_flag), .irq_o(irq));

  tsp_thermistor_model therm (.clk_i(clk), .bias_i(bias), .hot_i(hot),
    .temp_low_o(ext_low), .temp_recover_o(ext_rec));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic tsp_word_t xs(input tsp_word_t s);
    tsp_word_t x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic wr_reg(input tsp_addr_t a, input tsp_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // the read result is noted here and checked by the monitor a cycle later
  task automatic rd_reg(input tsp_addr_t a, input tsp_word_t e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  // registered outputs are looked at mid-cycle, clear of the edge
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic count_bias(output int c);
    c = 0;
    repeat (64) begin
      @(posedge clk);
      if (bias === 1'b1) c++;
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) `CHK(rdata, exp_q.pop_front(), "read data")
    rd_seen <= rd;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    {rstn, wr, rd, int_over, int_rec, hot, charge_overcurrent_flag, discharge_overcurrent_flag, sc} = '0;
    addr  = 8'h00;
    wdata = 32'h0;
    seed  = 32'h0000_5bbb;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(`TSP_REG_CTRL, 32'h0);
    rd_reg(`TSP_REG_AOSEL, 32'h0);
    rd_reg(8'h1c, 32'h0);
    $display("test reset done");
    count_bias(n);
    `CHK(n, 5, "scan on time")
    wr_reg(`TSP_REG_AOSEL, 32'h8);
    settle(2);
    count_bias(n);
    `CHK(n, 64, "bias held while external selected")
    wr_reg(`TSP_REG_CTRL, 32'hc);
    wr_reg(`TSP_REG_AOSEL, 32'h0);
    settle(2);
    count_bias(n);
    `CHK(n, 64, "forced bias")
    wr_reg(`TSP_REG_CTRL, 32'h4);
    settle(2);
    count_bias(n);
    `CHK(n, 0, "scan not stopped")
    $display("test scan done");
    for (int k = 0; k < 16; k++) begin
      wr_reg(`TSP_REG_AOSEL, k);
      settle(2);
      `CHK(route_cell, (k >= 1 && k <= 7) ? 7'(1 << (k - 1)) : 7'h0, "cell route")
      `CHK(route_ext, k == 8, "ext route")
      `CHK(route_int, k == 9, "int route")
      `CHK(bias, k == 8, "bias by select")
    end
    wr_reg(`TSP_REG_AOSEL, 32'h0);
    for (int f = 0; f < 3; f++) begin
      @(posedge clk);
      {charge_overcurrent_flag, discharge_overcurrent_flag, sc} <= 3'(1 << f);
      settle(2);
      `CHK(bias, 1'b1, "bias on overcurrent")
      @(posedge clk);
      {charge_overcurrent_flag, discharge_overcurrent_flag, sc} <= 3'b000;
    end
    $display("test select done");
    repeat (3) begin
      seed = xs(seed);
      v = seed & 32'h7f;
      wr_reg(`TSP_REG_BAL, v);
      rd_reg(`TSP_REG_BAL, v);
      settle(0);
      `CHK(bal_sw, v[6:0], "balance switches")
    end
    wr_reg(`TSP_REG_IRQ_MASK, 32'h3);
    wr_reg(`TSP_REG_CTRL, 32'h3);
    @(posedge clk);
    int_over <= 1'b1;
    settle(6);
    `CHK({chg, dsg, bal_sw}, 9'h0, "switches after internal hot")
    `CHK({internal_overtemp_flag, irq}, 2'b11, "internal flag or irq")
    rd_reg(`TSP_REG_CTRL, 32'h0);
    wr_reg(`TSP_REG_CTRL, 32'h3);
    wr_reg(`TSP_REG_BAL, 32'h7f);
    settle(1);
    `CHK({chg, dsg, bal_sw}, 9'h0, "writes not ignored in shutdown")
    wr_reg(`TSP_REG_IRQ_MASK, 32'h0);
    settle(1);
    `CHK(irq, 1'b0, "masked irq")
    @(posedge clk);
    int_over <= 1'b0;
    int_rec  <= 1'b1;
    settle(6);
    wr_reg(`TSP_REG_CTRL, 32'h3);
    wr_reg(`TSP_REG_IRQ_STAT, 32'h3);
    settle(1);
    `CHK({chg, dsg, bal_sw, internal_overtemp_flag}, {2'b11, v[6:0], 1'b0}, "recovery")
    @(posedge clk);
    int_rec <= 1'b0;
    wr_reg(`TSP_REG_CTRL, 32'h13);
    @(posedge clk);
    int_over <= 1'b1;
    settle(6);
    `CHK({chg, dsg}, 2'b11, "internal response not disabled")
    @(posedge clk);
    int_over <= 1'b0;
    $display("test internal done");
    wr_reg(`TSP_REG_CTRL, 32'h27);
    wr_reg(`TSP_REG_AOSEL, 32'h8);
    hot <= 1'b1;
    settle(10);
    `CHK({chg, dsg}, 2'b11, "external response not disabled")
    wr_reg(`TSP_REG_CTRL, 32'h7);
    settle(6);
    `CHK({chg, dsg, external_overtemp_flag}, 3'b001, "external shutdown")
    `CHK(route_ext, 1'b1, "monitoring lost in shutdown")
    @(posedge clk);
    hot <= 1'b0;
    settle(6);
    wr_reg(`TSP_REG_CTRL, 32'h7);
    settle(1);
    `CHK({chg, dsg}, 2'b11, "external recovery")
    $display("test external done");
    settle(3);
    end_of_test();
  end
endmodule

/* sim/tsp_thermistor_model.sv */
// thermistor divider and threshold comparators as seen through the bias output
`timescale 1ns/1ps
module tsp_thermistor_model (
  // clock and bias from the block
  input  wire logic clk_i,
  input  wire logic bias_i,
  // pack temperature chosen by the bench
  input  wire logic hot_i,
  // comparator outputs
  output logic      temp_low_o,
  output logic      temp_recover_o
);
  logic junk = 1'b0;
  // an unpowered divider floats, so the comparators wander every cycle
  always_ff @(posedge clk_i) begin
    junk <= ~junk;
  end
  // a reading only means something while the divider is powered
  assign temp_low_o     = bias_i ? hot_i : junk;
  assign temp_recover_o = bias_i ? ~hot_i : ~junk;
endmodule
